/* hdl/tcd_consts.vh */
// What this block does
// - two identical channels, each fed by pin, timer 2 or software requests
// - fetch and deposit run as one unbroken pair, nothing between them
// - fetched data goes to a holding register, deposit writes it out
// - source and destination each choose memory or I/O space
// - byte or word width per channel, word refused on the 8-bit bus
// - odd source word on 16-bit bus runs as two fetches, odd destination word as two deposits
// - 20-bit source and destination pointers over a flat 1 Mbyte space
// - I/O cycles run at any pointer address, also above 64K
// - pointers step up, down or stay, by two for words, one for bytes
// - no request is honoured until software arms the channel
// - request pin sampled on falling edge of processor clock output
// - at least four clocks from sampled pin request to cycle start
// - latched pin request cleared as the last fetch completes and the deposit starts
// - source gets at least three clocks after its fetch to withdraw
// - destination-synchronized transfers add two idle states after deposit
// - bus is released during those two idle states
// - sync type selectable: source, destination, timer or unsynchronized
// - timer mode runs one transfer per timer 2 maximum count
// - unsynchronized mode runs back-to-back until count zero or NMI
// - no transfer acknowledge output is driven
// - transfers continue while request active and limit not passed
// - 16-bit count drops by one per transfer, may stop at zero
// - unsynchronized transfers always disarm at count zero
// - equal priority rotates, otherwise high priority channel wins
`ifndef TCD_CONSTS_VH
`define TCD_CONSTS_VH
`define TCD_OFF_SRC     6'h00
`define TCD_OFF_DST     6'h04
`define TCD_OFF_CNT     6'h08
`define TCD_OFF_CTL     6'h0C
`define TCD_CH_STRIDE   6'h10
`define TCD_OFF_STAT    6'h20
`define TCD_CTL_ARM     0
`define TCD_CTL_SMEM    1
`define TCD_CTL_DMEM    2
`define TCD_CTL_SINC    4:3
`define TCD_CTL_DINC    6:5
`define TCD_CTL_WORD    7
`define TCD_CTL_SYNC    9:8
`define TCD_CTL_TC      10
`define TCD_CTL_PRI     11
`define TCD_CTL_SUSP    12
`define TCD_CTL_W       13
`define TCD_CTL_RST     13'h0000
`define TCD_PTR_RST     20'h00000
`define TCD_CNT_RST     16'h0000
`define TCD_SYNC_NONE   2'h0
`define TCD_SYNC_SRC    2'h1
`define TCD_SYNC_DST    2'h2
`define TCD_SYNC_TMR    2'h3
`define TCD_STEP_INC    2'h1
`define TCD_STEP_DEC    2'h2
`define TCD_REQ_LAT     4
`define TCD_IDLE_GAP    2
`endif

/* hdl/tcd_dma_unit.v */
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tcd_consts.vh"
module tcd_dma_unit #(
   parameter BUS8 = 0
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // avalon-mm register slave
   input  wire [5:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   output reg  [31:0] avs_readdata_o,
   output reg         avs_waitrequest_o,
   // request sources
   input  wire [1:0]  transfer_request_pin_i,
   input  wire        processor_clock_output_i,
   input  wire        timer2_max_i,
   input  wire        nmi_active_i,
   // bus cycle engine
   output reg         bce_req_o,
   output reg         bce_we_o,
   output reg         bce_io_o,
   output reg         bce_word_o,
   output reg         bce_lock_o,
   output reg         bce_dma_o,
   output reg  [19:0] bce_addr_o,
   output reg  [15:0] bce_wdata_o,
   input  wire [15:0] bce_rdata_i,
   input  wire        bce_done_i
);
   localparam S_IDLE  = 3'h0;
   localparam S_WAIT  = 3'h1;
   localparam S_FETCH = 3'h2;
   localparam S_DEP   = 3'h3;
   localparam S_GAP   = 3'h4;
   localparam [2:0] BLANK_LEN = `TCD_REQ_LAT;

   function [19:0] step_ptr;
      input [19:0] p;
      input [1:0]  mode;
      input        word;
      begin
         case (mode)
            `TCD_STEP_INC: step_ptr = p + (word ? 20'h00002 : 20'h00001);
            `TCD_STEP_DEC: step_ptr = p - (word ? 20'h00002 : 20'h00001);
            default:       step_ptr = p;
         endcase
      end
   endfunction

   function is_ext;
      input [1:0] sync;
      begin
         is_ext = (sync == `TCD_SYNC_SRC) || (sync == `TCD_SYNC_DST);
      end
   endfunction

   reg [19:0] src_reg [0:1];
   reg [19:0] dst_reg [0:1];
   reg [15:0] cnt_reg [0:1];
   reg [`TCD_CTL_W-1:0] ctl_reg [0:1];
   reg [1:0]  rq_lat_reg;
   reg [1:0]  pin_s1_reg;
   reg [1:0]  pin_s2_reg;
   reg        co_s1_reg;
   reg        co_s2_reg;
   reg        co_d_reg;
   reg [2:0]  st_reg;
   reg        cur_reg;
   reg        rot_reg;
   reg        part_reg;
   reg [2:0]  tmr_reg;
   reg [15:0] hold_reg;
   reg [2:0]  blank_reg [0:1];

   // register bus decode
   wire       acc_w   = avs_write_i & ~avs_waitrequest_o;
   wire       reg_ch  = avs_address_i[4];
   wire [5:0] reg_off = {2'b00, avs_address_i[3:0]};
   wire       in_ch   = ~avs_address_i[5];

   // falling edge of synchronized processor clock output
   wire co_fall = co_d_reg & ~co_s2_reg;

   // per-channel effective settings
   wire [1:0] want;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_want
         wire [1:0] sy = ctl_reg[g][`TCD_CTL_SYNC];
         assign want[g] = ctl_reg[g][`TCD_CTL_ARM] & ~ctl_reg[g][`TCD_CTL_SUSP] &
                          ~nmi_active_i &
                          ((sy == `TCD_SYNC_NONE) | rq_lat_reg[g]);
      end
   endgenerate

   // arbitration: fixed when priorities differ, rotating when equal
   wire pri0 = ctl_reg[0][`TCD_CTL_PRI];
   wire pri1 = ctl_reg[1][`TCD_CTL_PRI];
   reg  pick;
   always @* begin
      if (want == 2'b01)
         pick = 1'b0;
      else if (want == 2'b10)
         pick = 1'b1;
      else if (pri0 != pri1)
         pick = pri1;
      else
         pick = rot_reg;
   end

   // current channel view
   wire [`TCD_CTL_W-1:0] cctl = ctl_reg[cur_reg];
   wire [1:0]  csync  = cctl[`TCD_CTL_SYNC];
   wire        cword  = cctl[`TCD_CTL_WORD] & (BUS8 == 0);
   wire [19:0] csrc   = src_reg[cur_reg];
   wire [19:0] cdst   = dst_reg[cur_reg];
   wire        s_split = cword & csrc[0];
   wire        d_split = cword & cdst[0];
   wire [15:0] cnt_dec = cnt_reg[cur_reg] - 16'h0001;
   wire        last_dep = (st_reg == S_DEP) & bce_done_i & (~d_split | part_reg);
   wire        dep_start = (st_reg == S_FETCH) & bce_done_i & (~s_split | part_reg);

   // pin and clock output synchronizers
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1_reg <= 2'b00;
         pin_s2_reg <= 2'b00;
         co_s1_reg  <= 1'b0;
         co_s2_reg  <= 1'b0;
         co_d_reg   <= 1'b0;
      end else begin
         pin_s1_reg <= transfer_request_pin_i;
         pin_s2_reg <= pin_s1_reg;
         co_s1_reg  <= processor_clock_output_i;
         co_s2_reg  <= co_s1_reg;
         co_d_reg   <= co_s2_reg;
      end
   end

   // request latches; a new request beats a same-cycle clear
   // synced pin lags the pin, so its old level is masked while busy and just after
   integer c;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rq_lat_reg   <= 2'b00;
         blank_reg[0] <= 3'h0;
         blank_reg[1] <= 3'h0;
      end else begin
         for (c = 0; c < 2; c = c + 1) begin
            if (cur_reg == c && dep_start)
               blank_reg[c] <= BLANK_LEN;
            else if (blank_reg[c] != 3'h0)
               blank_reg[c] <= blank_reg[c] - 3'h1;
            if (!ctl_reg[c][`TCD_CTL_ARM])
               rq_lat_reg[c] <= 1'b0;
            else if (is_ext(ctl_reg[c][`TCD_CTL_SYNC]) && co_fall && pin_s2_reg[c] &&
                     blank_reg[c] == 3'h0 && !(cur_reg == c && st_reg != S_IDLE))
               rq_lat_reg[c] <= 1'b1;
            else if (ctl_reg[c][`TCD_CTL_SYNC] == `TCD_SYNC_TMR && timer2_max_i)
               rq_lat_reg[c] <= 1'b1;
            // cleared as the deposit starts, so the peripheral's drop is seen
            else if (cur_reg == c && dep_start)
               rq_lat_reg[c] <= 1'b0;
         end
      end
   end

   // register file and transfer engine
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         src_reg[0] <= `TCD_PTR_RST;
         src_reg[1] <= `TCD_PTR_RST;
         dst_reg[0] <= `TCD_PTR_RST;
         dst_reg[1] <= `TCD_PTR_RST;
         cnt_reg[0] <= `TCD_CNT_RST;
         cnt_reg[1] <= `TCD_CNT_RST;
         ctl_reg[0] <= `TCD_CTL_RST;
         ctl_reg[1] <= `TCD_CTL_RST;
         st_reg     <= S_IDLE;
         cur_reg    <= 1'b0;
         rot_reg    <= 1'b1;
         part_reg   <= 1'b0;
         tmr_reg    <= 3'h0;
         hold_reg   <= 16'h0000;
         bce_req_o  <= 1'b0;
         bce_we_o   <= 1'b0;
         bce_io_o   <= 1'b0;
         bce_word_o <= 1'b0;
         bce_lock_o <= 1'b0;
         bce_dma_o  <= 1'b0;
         bce_addr_o <= 20'h00000;
         bce_wdata_o <= 16'h0000;
      end else begin
         // software writes; engine updates below take precedence
         if (acc_w && in_ch) begin
            case (reg_off)
               `TCD_OFF_SRC: src_reg[reg_ch] <= avs_writedata_i[19:0];
               `TCD_OFF_DST: dst_reg[reg_ch] <= avs_writedata_i[19:0];
               `TCD_OFF_CNT: cnt_reg[reg_ch] <= avs_writedata_i[15:0];
               `TCD_OFF_CTL: ctl_reg[reg_ch] <= avs_writedata_i[`TCD_CTL_W-1:0];
               default: ;
            endcase
         end
         case (st_reg)
            S_IDLE: begin
               bce_lock_o <= 1'b0;
               bce_dma_o  <= 1'b0;
               if (want != 2'b00) begin
                  cur_reg  <= pick;
                  part_reg <= 1'b0;
                  tmr_reg  <= 3'h0;
                  bce_dma_o <= 1'b1;
                  st_reg   <= S_WAIT;
               end else begin
                  rot_reg <= 1'b1;
               end
            end
            S_WAIT: begin
               tmr_reg <= tmr_reg + 3'h1;
               // pin requests need the full overhead; internal ones go now
               if (!is_ext(csync) || tmr_reg >= `TCD_REQ_LAT - 2) begin
                  st_reg     <= S_FETCH;
                  bce_req_o  <= 1'b1;
                  bce_we_o   <= 1'b0;
                  bce_lock_o <= 1'b1;
                  bce_io_o   <= ~cctl[`TCD_CTL_SMEM];
                  bce_word_o <= cword & ~s_split;
                  bce_addr_o <= csrc;
               end
            end
            S_FETCH: begin
               if (bce_done_i) begin
                  if (!s_split)
                     hold_reg <= bce_rdata_i;
                  else if (!part_reg)
                     hold_reg[7:0] <= bce_rdata_i[7:0];
                  else
                     hold_reg[15:8] <= bce_rdata_i[7:0];
                  if (s_split && !part_reg) begin
                     part_reg   <= 1'b1;
                     bce_addr_o <= csrc + 20'h00001;
                  end else begin
                     part_reg   <= 1'b0;
                     st_reg     <= S_DEP;
                     bce_we_o   <= 1'b1;
                     bce_io_o   <= ~cctl[`TCD_CTL_DMEM];
                     bce_word_o <= cword & ~d_split;
                     bce_addr_o <= cdst;
                     if (!s_split)
                        bce_wdata_o <= bce_rdata_i;
                     else if (d_split)
                        bce_wdata_o <= {8'h00, hold_reg[7:0]};
                     else
                        bce_wdata_o <= {bce_rdata_i[7:0], hold_reg[7:0]};
                  end
               end
            end
            S_DEP: begin
               if (bce_done_i) begin
                  if (d_split && !part_reg) begin
                     part_reg    <= 1'b1;
                     bce_addr_o  <= cdst + 20'h00001;
                     bce_wdata_o <= {8'h00, hold_reg[15:8]};
                  end else begin
                     bce_req_o  <= 1'b0;
                     bce_we_o   <= 1'b0;
                     src_reg[cur_reg] <= step_ptr(csrc, cctl[`TCD_CTL_SINC], cword);
                     dst_reg[cur_reg] <= step_ptr(cdst, cctl[`TCD_CTL_DINC], cword);
                     cnt_reg[cur_reg] <= cnt_dec;
                     if (cnt_dec == 16'h0000 &&
                         (cctl[`TCD_CTL_TC] || csync == `TCD_SYNC_NONE))
                        ctl_reg[cur_reg][`TCD_CTL_ARM] <= 1'b0;
                     rot_reg <= ~cur_reg;
                     tmr_reg <= 3'h0;
                     if (csync == `TCD_SYNC_DST) begin
                        st_reg     <= S_GAP;
                        bce_lock_o <= 1'b0;
                        bce_dma_o  <= 1'b0;
                     end else begin
                        st_reg <= S_IDLE;
                     end
                  end
               end
            end
            S_GAP: begin
               // bus is free here; the other channel may win next
               tmr_reg <= tmr_reg + 3'h1;
               rot_reg <= 1'b1;
               if (tmr_reg >= `TCD_IDLE_GAP - 1)
                  st_reg <= S_IDLE;
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end

   // register read path; one wait cycle per access
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      if (in_ch) begin
         case (reg_off)
            `TCD_OFF_SRC: rd_mux = {12'h000, src_reg[reg_ch]};
            `TCD_OFF_DST: rd_mux = {12'h000, dst_reg[reg_ch]};
            `TCD_OFF_CNT: rd_mux = {16'h0000, cnt_reg[reg_ch]};
            `TCD_OFF_CTL: rd_mux = {19'h00000, ctl_reg[reg_ch]};
            default:      rd_mux = 32'h00000000;
         endcase
      end else if (avs_address_i == `TCD_OFF_STAT) begin
         rd_mux = {24'h000000, rq_lat_reg,
                   ctl_reg[1][`TCD_CTL_ARM], ctl_reg[0][`TCD_CTL_ARM],
                   st_reg == S_GAP, cur_reg, st_reg != S_IDLE, 1'b0};
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h00000000;
      end else begin
         if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= rd_mux;
         end else begin
            avs_waitrequest_o <= 1'b1;
         end
      end
   end
endmodule

/* tb/tcd_bus_model.sv */
`timescale 1ns/1ps
module tcd_bus_model (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // cycle from the unit, latency from the bench
   input  wire        req_i,
   input  wire        word_i,
   input  wire [19:0] addr_i,
   input  wire [2:0]  lat_i,
   // answer
   output reg  [15:0] rdata_o,
   output reg         done_o
);
   reg  [2:0]  wait_reg;
   reg  [15:0] junk_reg;
   wire [7:0]  lo_byte = addr_i[7:0] ^ 8'hA5;
   wire [7:0]  hi_byte = (addr_i[7:0] + 8'h01) ^ 8'hA5;
   // data rolls outside done so a stale capture never matches
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_reg <= 3'h0;
         done_o   <= 1'b0;
         rdata_o  <= 16'h0000;
         junk_reg <= 16'h0000;
      end else if (req_i && !done_o && wait_reg == lat_i) begin
         wait_reg <= 3'h0;
         done_o   <= 1'b1;
         rdata_o  <= word_i ? {hi_byte, lo_byte} : {8'h00, lo_byte};
      end else begin
         wait_reg <= (req_i && !done_o) ? wait_reg + 3'h1 : 3'h0;
         done_o   <= 1'b0;
         junk_reg <= junk_reg + 16'h1357;
         rdata_o  <= junk_reg;
      end
   end
endmodule

/* tb/tcd_dma_unit_props.sv */
`timescale 1ns/1ps
module tcd_dma_unit_props #(
   parameter BUS8 = 0
) (
   // clock and reset
   input wire        clk_i,
   input wire        rst_n_i,
   // register bus
   input wire [5:0]  avs_address_i,
   input wire        avs_read_i,
   input wire        avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [31:0] avs_readdata_o,
   input wire        avs_waitrequest_o,
   // request sources
   input wire [1:0]  transfer_request_pin_i,
   input wire        processor_clock_output_i,
   input wire        timer2_max_i,
   input wire        nmi_active_i,
   // bus cycle engine
   input wire        bce_req_o,
   input wire        bce_we_o,
   input wire        bce_io_o,
   input wire        bce_word_o,
   input wire        bce_lock_o,
   input wire        bce_dma_o,
   input wire [19:0] bce_addr_o,
   input wire [15:0] bce_wdata_o,
   input wire [15:0] bce_rdata_i,
   input wire        bce_done_i
);
   reg written_reg;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // any write counts, so arming through any path is never flagged
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         written_reg <= 1'b0;
      end else if (avs_write_i && !avs_waitrequest_o) begin
         written_reg <= 1'b1;
      end
   end
   sequence s_fetch_done;
      bce_req_o && !bce_we_o && bce_done_i;
   endsequence
   sequence s_word_pair;
      s_fetch_done ##0 bce_word_o ##1 (bce_we_o && bce_word_o);
   endsequence
   a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest late");
   a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest long");
   a_lock_pair: assert property (bce_req_o |-> bce_lock_o && bce_dma_o) else $error("pair unlocked");
   a_fetch_then_more: assert property (s_fetch_done |=> bce_req_o) else $error("gap after fetch");
   a_held_data: assert property (s_word_pair |-> bce_wdata_o == $past(bce_rdata_i)) else $error("bad deposit");
   a_cycle_stable: assert property (bce_req_o && !bce_done_i |=> bce_req_o && $stable(bce_addr_o)
      && $stable(bce_we_o) && $stable(bce_io_o) && $stable(bce_word_o)) else $error("cycle moved");
   a_armed_first: assert property (!written_reg |-> !bce_req_o) else $error("unarmed cycle");
   a_pin_latency: assert property ($rose(transfer_request_pin_i[0]) && !bce_dma_o |=> !bce_req_o [*4])
      else $error("pin too fast");
   a_bus8_bytes: assert property (bce_req_o |-> BUS8 == 0 || !bce_word_o) else $error("word on 8-bit");
endmodule
bind tcd_dma_unit tcd_dma_unit_props #(.BUS8(BUS8)) u_tcd_dma_unit_props (
   .clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
   .avs_waitrequest_o, .transfer_request_pin_i, .processor_clock_output_i, .timer2_max_i, .nmi_active_i,
   .bce_req_o, .bce_we_o, .bce_io_o, .bce_word_o, .bce_lock_o, .bce_dma_o, .bce_addr_o, .bce_wdata_o,
   .bce_rdata_i, .bce_done_i
);

/* tb/tcd_dma_unit_tb.sv */
`timescale 1ns/1ps
module tcd_dma_unit_tb;
   logic        clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, processor_clock_output_i;
   logic        timer2_max_i, nmi_active_i, bce_req_o, bce_we_o, bce_io_o, bce_word_o, bce_lock_o;
   logic        bce_dma_o, bce_done_i;
   logic [1:0]  transfer_request_pin_i;
   logic [2:0]  lat;
   logic [5:0]  avs_address_i;
   logic [15:0] bce_wdata_o, bce_rdata_i;
   logic [19:0] bce_addr_o;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic [19:0] dep_addr[$];
   logic [15:0] dep_data[$];
   int          bad_count, comparisons, fetches;
   tcd_dma_unit u_tcd_dma_unit (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
      .avs_readdata_o, .avs_waitrequest_o, .transfer_request_pin_i, .processor_clock_output_i, .timer2_max_i,
      .nmi_active_i, .bce_req_o, .bce_we_o, .bce_io_o, .bce_word_o, .bce_lock_o, .bce_dma_o, .bce_addr_o,
      .bce_wdata_o, .bce_rdata_i, .bce_done_i);
   tcd_bus_model u_tcd_bus_model (.clk_i, .rst_n_i, .req_i(bce_req_o), .word_i(bce_word_o), .addr_i(bce_addr_o),
      .lat_i(lat), .rdata_o(bce_rdata_i), .done_o(bce_done_i));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      processor_clock_output_i <= ~processor_clock_output_i;
      if (bce_req_o && bce_done_i && bce_we_o) begin
         dep_addr.push_back(bce_addr_o);
         dep_data.push_back(bce_io_o ? bce_wdata_o | 16'h8000 : bce_wdata_o);
      end
      if (bce_req_o && bce_done_i && !bce_we_o) fetches++;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      check("waitrequest", 32'h0, avs_waitrequest_o);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic cfg(input logic [5:0] b, input logic [19:0] s, d, input logic [15:0] c, input logic [12:0] ctl);
      fetches = 0;
      dep_addr.delete();
      dep_data.delete();
      av(1'b1, b, s);
      av(1'b1, b + 6'h04, d);
      av(1'b1, b + 6'h08, c);
      av(1'b1, b + 6'h0C, ctl);
   endtask
   task automatic wait_deps(input int n);
      int k;
      k = 0;
      while (dep_addr.size() < n && k < 400) begin
         @(posedge clk_i);
         k++;
      end
      repeat (20) @(posedge clk_i);
      check("transfers", n, dep_addr.size());
   endtask
   task automatic pulse;
      timer2_max_i <= 1'b1;
      @(posedge clk_i);
      timer2_max_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic t_regs;
      av(1'b0, 6'h0C, 32'h0);
      check("ctl reset", 32'h0, rd);
      av(1'b1, 6'h20, 32'hFF);
      av(1'b0, 6'h20, 32'h0);
      check("stat", 32'h0, rd);
      av(1'b1, 6'h00, 32'hFFFFFFFF);
      av(1'b0, 6'h00, 32'h0);
      check("src width", 32'h000FFFFF, rd);
      av(1'b1, 6'h30, 32'h5A5A5A5A);
      av(1'b0, 6'h30, 32'h0);
      check("unmapped", 32'h0, rd);
   endtask
   task automatic t_unsync;
      lat <= 3'h3;
      cfg(6'h00, 20'h00010, 20'h12345, 16'h0002, 13'h004B);
      wait_deps(2);
      check("dst high io", 32'h12345, dep_addr[0]);
      check("dst down", 32'h12344, dep_addr[1]);
      check("data0", 32'h80B5, dep_data[0] & 16'h80FF);
      check("data1", 32'h80B4, dep_data[1] & 16'h80FF);
      av(1'b0, 6'h00, 32'h0);
      check("src up", 32'h12, rd);
      av(1'b0, 6'h08, 32'h0);
      check("count", 32'h0, rd);
      av(1'b0, 6'h0C, 32'h0);
      check("disarmed", 32'h4A, rd);
      lat <= 3'h0;
   endtask
   task automatic t_word_odd;
      cfg(6'h00, 20'h00021, 20'h00100, 16'h0001, 13'h04A7);
      wait_deps(1);
      check("odd fetches", 32'h2, fetches);
      check("word data", 32'h8784, dep_data[0]);
      av(1'b0, 6'h04, 32'h0);
      check("dst by two", 32'h102, rd);
      cfg(6'h00, 20'h00022, 20'h00100, 16'h0001, 13'h04A7);
      wait_deps(1);
      check("even fetches", 32'h1, fetches);
      check("even word", 32'h8687, dep_data[0]);
   endtask
   task automatic t_timer;
      cfg(6'h10, 20'h00040, 20'h00300, 16'h0003, 13'h070E);
      pulse();
      wait_deps(0);
      av(1'b1, 6'h1C, 32'h070F);
      pulse();
      wait_deps(1);
      pulse();
      wait_deps(2);
   endtask
   task automatic t_pin;
      int n;
      cfg(6'h00, 20'h00050, 20'h00400, 16'h0005, 13'h052F);
      n = 0;
      transfer_request_pin_i <= 2'b01;
      while (bce_req_o !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      check("pin latency", 32'h1, n >= 4 && n < 200);
      while (bce_we_o !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      transfer_request_pin_i <= 2'b00;
      wait_deps(1);
      dep_addr.delete();
      transfer_request_pin_i <= 2'b01;
      wait_deps(4);
      transfer_request_pin_i <= 2'b00;
   endtask
   task automatic t_dest;
      int n;
      cfg(6'h10, 20'h00060, 20'h00500, 16'h0002, 13'h0607);
      transfer_request_pin_i <= 2'b10;
      n = 0;
      while (!(bce_req_o === 1'b1 && bce_we_o === 1'b1 && bce_done_i === 1'b1) && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      @(posedge clk_i);
      check("bus released", 32'h0, {bce_dma_o, bce_lock_o});
      n = 0;
      while (bce_req_o !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      check("idle gap", 32'h1, n >= 3 && n < 200);
      wait_deps(2);
      transfer_request_pin_i <= 2'b00;
   endtask
   task automatic t_prio;
      nmi_active_i <= 1'b1;
      cfg(6'h00, 20'h00070, 20'h00200, 16'h0002, 13'h0007);
      cfg(6'h10, 20'h00080, 20'h00300, 16'h0002, 13'h0007);
      wait_deps(0);
      nmi_active_i <= 1'b0;
      wait_deps(4);
      for (int i = 0; i < 4; i++) check("rotation", i[0] ? 32'h200 : 32'h300, dep_addr[i]);
   endtask
   task automatic summarize;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #150000;
      bad_count++;
      summarize();
   end
   initial begin
      {rst_n_i, avs_read_i, avs_write_i, timer2_max_i, nmi_active_i, processor_clock_output_i} = 6'h00;
      {avs_address_i, avs_writedata_i, transfer_request_pin_i, lat} = 43'h0;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_regs();
      t_unsync();
      t_word_odd();
      t_timer();
      t_pin();
      t_dest();
      t_prio();
      summarize();
   end
endmodule
